// ===== src/null_bal_ctrl.v
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ps
`include "null_bal_map.vh"
module null_bal_ctrl #(
    parameter W = 24,
    parameter FULL_SCALE = 24'h3FFFFF,
    parameter QUAL_CYCLES = `QUAL_TIME_MS * `CLK_MHZ * 1000,
    parameter SEQ_CYCLES = `SEQ_TIME_MS * `CLK_MHZ * 1000,
    parameter TX_CYCLES = `CLK_MHZ * 1000000 / `TX_RATE_HZ
)(
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // measurement in
    input wire signed [W-1:0] meas_raw,
    input wire meas_vld,
    // zero request input
    input wire zero_req,
    // build option
    input wire open_emitter,
    // serial measurement out
    output reg [W-1:0] tx_data,
    output reg tx_valid,
    // analog output state
    output wire aout_valid,
    // switching outputs
    output wire relay_drive_a,
    output wire relay_drive_b,
    // interrupt
    output wire irq
);
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;
    localparam signed [W+7:0] OFF_LIM = (FULL_SCALE * `OFFSET_PCT) / 100;

    reg state_q;
    reg [31:0] seq_cnt_q;
    reg do_off_q;
    reg do_zero_q;
    reg [4:0] ctrl_q;
    reg signed [W-1:0] on_a_q;
    reg signed [W-1:0] off_a_q;
    reg signed [W-1:0] on_b_q;
    reg signed [W-1:0] off_b_q;
    reg [15:0] gage_q;
    reg signed [W-1:0] offset_q;
    reg signed [W-1:0] zero_q;
    reg signed [W-1:0] raw_last_q;
    reg signed [W-1:0] value_q;
    reg value_vld_q;
    reg [31:0] tx_cnt_q;
    reg [4:0] irq_stat_q;
    reg [4:0] irq_mask_q;
    reg relay_a_prev_q;
    reg relay_b_prev_q;
    reg busy_prev_q;

    wire qual_pulse;
    wire relay_a;
    wire relay_b;
    wire busy = (state_q == ST_RUN);
    wire fbus_on = ctrl_q[`CTRL_FBUS];
    wire logger = ctrl_q[`CTRL_LOGGER];

    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    wire wr = psel && penable && pwrite;
    wire rd_sel = psel && !pwrite;
    reg mapped;
    reg is_cfg;

    always @*
    begin
        mapped = 1'b1;
        is_cfg = 1'b1;
        if (paddr == `REG_CTRL)
            is_cfg = 1'b1;
        else if (paddr == `REG_CMD)
            is_cfg = 1'b0;
        else if (paddr == `REG_STATUS)
            is_cfg = 1'b0;
        else if (paddr == `REG_ON_A || paddr == `REG_OFF_A)
            is_cfg = 1'b1;
        else if (paddr == `REG_ON_B || paddr == `REG_OFF_B)
            is_cfg = 1'b1;
        else if (paddr == `REG_GAGE)
            is_cfg = 1'b1;
        else if (paddr == `REG_OFFSET || paddr == `REG_ZERO)
            is_cfg = 1'b0;
        else if (paddr == `REG_IRQ_STAT || paddr == `REG_IRQ_MASK)
            is_cfg = 1'b0;
        else
        begin
            mapped = 1'b0;
            is_cfg = 1'b0;
        end
    end

    // fieldbus off and factory restore stay reachable, every other configuration write is locked
    wire ctrl_unlock = (paddr == `REG_CTRL) &&
        (!pwdata[`CTRL_FBUS] || pwdata[`CTRL_RESTORE]);
    wire gage_bad = (paddr == `REG_GAGE) &&
        ((pwdata[15:0] < `GAGE_MIN) || (pwdata[15:0] > `GAGE_MAX) || (pwdata[31:16] != 16'h0));
    wire refused = is_cfg && ((fbus_on && !ctrl_unlock) || gage_bad);
    wire cfg_wr = wr && is_cfg && !refused;
    wire cmd_wr = wr && (paddr == `REG_CMD);

    assign pready = 1'b1;
    assign pslverr = psel && penable && (!mapped || (pwrite && refused));

    always @*
    begin
        prdata = 32'h0;
        if (!rd_sel)
            prdata = 32'h0;
        else if (paddr == `REG_CTRL)
            prdata = {27'h0, ctrl_q};
        else if (paddr == `REG_STATUS)
            prdata = {28'h0, fbus_on, relay_b, relay_a, busy};
        else if (paddr == `REG_ON_A)
            prdata = {{(32-W){on_a_q[W-1]}}, on_a_q};
        else if (paddr == `REG_OFF_A)
            prdata = {{(32-W){off_a_q[W-1]}}, off_a_q};
        else if (paddr == `REG_ON_B)
            prdata = {{(32-W){on_b_q[W-1]}}, on_b_q};
        else if (paddr == `REG_OFF_B)
            prdata = {{(32-W){off_b_q[W-1]}}, off_b_q};
        else if (paddr == `REG_GAGE)
            prdata = {16'h0, gage_q};
        else if (paddr == `REG_OFFSET)
            prdata = {{(32-W){offset_q[W-1]}}, offset_q};
        else if (paddr == `REG_ZERO)
            prdata = {{(32-W){zero_q[W-1]}}, zero_q};
        else if (paddr == `REG_IRQ_STAT)
            prdata = {27'h0, irq_stat_q};
        else if (paddr == `REG_IRQ_MASK)
            prdata = {27'h0, irq_mask_q};
    end

    // ----------------------------------------
    // configuration registers
    // ----------------------------------------
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q <= `CTRL_RESET;
            on_a_q <= {W{1'b0}};
            off_a_q <= {W{1'b0}};
            on_b_q <= {W{1'b0}};
            off_b_q <= {W{1'b0}};
            gage_q <= `GAGE_RESET;
            irq_mask_q <= 5'h0;
        end
        else if (cfg_wr && paddr == `REG_CTRL && pwdata[`CTRL_RESTORE])
        begin
            ctrl_q <= `CTRL_RESET;
            on_a_q <= {W{1'b0}};
            off_a_q <= {W{1'b0}};
            on_b_q <= {W{1'b0}};
            off_b_q <= {W{1'b0}};
            gage_q <= `GAGE_RESET;
        end
        else
        begin
            if (cfg_wr && paddr == `REG_CTRL)
                ctrl_q <= {1'b0, pwdata[3:0]};
            // host keeps on above off; no check, as written it is applied
            if (cfg_wr && paddr == `REG_ON_A)
                on_a_q <= pwdata[W-1:0];
            if (cfg_wr && paddr == `REG_OFF_A)
                off_a_q <= pwdata[W-1:0];
            if (cfg_wr && paddr == `REG_ON_B)
                on_b_q <= pwdata[W-1:0];
            if (cfg_wr && paddr == `REG_OFF_B)
                off_b_q <= pwdata[W-1:0];
            if (cfg_wr && paddr == `REG_GAGE)
                gage_q <= pwdata[15:0];
            if (wr && paddr == `REG_IRQ_MASK)
                irq_mask_q <= pwdata[4:0];
        end
    end

    // ----------------------------------------
    // zero request and null-balance sequence
    // ----------------------------------------
    zreq_qualify #(
        .HOLD_CYCLES(QUAL_CYCLES)
    ) u_qual (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .level_in(zero_req),
        .qual_pulse(qual_pulse)
    );

    wire pin_start = qual_pulse && !logger;
    wire cmd_full = cmd_wr && pwdata[`CMD_FULL];
    wire cmd_off = cmd_wr && (pwdata[`CMD_FULL] || pwdata[`CMD_OFFSET]);
    wire cmd_zero = cmd_wr && (pwdata[`CMD_FULL] || pwdata[`CMD_ZERO]);
    // a tick in the start cycle would land inside the sequence
    wire seq_start = !busy && (pin_start || cmd_off || cmd_zero);

    // offset clamped to the calibration range
    wire signed [W+7:0] raw_ext = raw_last_q;
    wire signed [W+7:0] off_clip = (raw_ext > OFF_LIM) ? OFF_LIM :
        (raw_ext < -OFF_LIM) ? -OFF_LIM : raw_ext;
    wire signed [W-1:0] off_new = do_off_q ? off_clip[W-1:0] : offset_q;

    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= ST_IDLE;
            seq_cnt_q <= 32'h0;
            do_off_q <= 1'b0;
            do_zero_q <= 1'b0;
            offset_q <= {W{1'b0}};
            zero_q <= {W{1'b0}};
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    seq_cnt_q <= 32'h0;
                    if (pin_start || cmd_full)
                    begin
                        state_q <= ST_RUN;
                        do_off_q <= 1'b1;
                        do_zero_q <= 1'b1;
                    end
                    else if (cmd_off || cmd_zero)
                    begin
                        state_q <= ST_RUN;
                        do_off_q <= cmd_off;
                        do_zero_q <= cmd_zero;
                    end
                end
                ST_RUN:
                begin
                    if (seq_cnt_q >= SEQ_CYCLES - 1)
                    begin
                        state_q <= ST_IDLE;
                        offset_q <= off_new;
                        if (do_zero_q)
                            zero_q <= raw_last_q - off_new;
                        do_off_q <= 1'b0;
                        do_zero_q <= 1'b0;
                    end
                    else
                        seq_cnt_q <= seq_cnt_q + 32'h1;
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    assign aout_valid = !busy;

    // ----------------------------------------
    // measurement path and serial output
    // ----------------------------------------
    wire tx_tick = (tx_cnt_q >= TX_CYCLES - 1);
    wire log_send = qual_pulse && logger;

    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            raw_last_q <= {W{1'b0}};
            value_q <= {W{1'b0}};
            value_vld_q <= 1'b0;
            tx_cnt_q <= 32'h0;
            tx_data <= {W{1'b0}};
            tx_valid <= 1'b0;
        end
        else
        begin
            value_vld_q <= meas_vld;
            if (meas_vld)
            begin
                raw_last_q <= meas_raw;
                value_q <= meas_raw - offset_q - zero_q;
            end
            tx_cnt_q <= tx_tick ? 32'h0 : tx_cnt_q + 32'h1;
            tx_valid <= 1'b0;
            if (log_send || (tx_tick && !logger && !busy && !seq_start))
            begin
                tx_data <= value_q;
                tx_valid <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // switching outputs
    // ----------------------------------------
    relay_chan #(
        .W(W)
    ) u_chan_a (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .value(value_q),
        .value_vld(value_vld_q),
        .eval_en(!busy && !busy_prev_q),
        .window_mode(ctrl_q[`CTRL_WIN_A]),
        .on_lvl(on_a_q),
        .off_lvl(off_a_q),
        .open_emitter(open_emitter),
        .active_q(relay_a),
        .pin_level(relay_drive_a)
    );

    relay_chan #(
        .W(W)
    ) u_chan_b (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .value(value_q),
        .value_vld(value_vld_q),
        .eval_en(!busy && !busy_prev_q),
        .window_mode(ctrl_q[`CTRL_WIN_B]),
        .on_lvl(on_b_q),
        .off_lvl(off_b_q),
        .open_emitter(open_emitter),
        .active_q(relay_b),
        .pin_level(relay_drive_b)
    );

    // ----------------------------------------
    // interrupts
    // ----------------------------------------
    wire [4:0] ev;
    assign ev[`EV_DONE] = busy && (seq_cnt_q >= SEQ_CYCLES - 1);
    assign ev[`EV_REFUSED] = wr && refused;
    assign ev[`EV_RELAY_A] = relay_a != relay_a_prev_q;
    assign ev[`EV_RELAY_B] = relay_b != relay_b_prev_q;
    assign ev[`EV_LOGGER] = log_send;
    wire [4:0] w1c = (wr && paddr == `REG_IRQ_STAT) ? pwdata[4:0] : 5'h0;

    // a new event wins over a clear in the same cycle
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            irq_stat_q <= 5'h0;
            relay_a_prev_q <= 1'b0;
            relay_b_prev_q <= 1'b0;
            busy_prev_q <= 1'b0;
        end
        else
        begin
            // value formed in the last busy cycle still holds the old offset
            busy_prev_q <= busy;
            irq_stat_q <= (irq_stat_q & ~w1c) | ev;
            relay_a_prev_q <= relay_a;
            relay_b_prev_q <= relay_b;
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);
endmodule // null_bal_ctrl

// ===== common/null_bal_map.vh
// Behaviour
// - config writes refused while fieldbus enabled, accepted after it is switched off
// - factory restore turns fieldbus enable on
// - zero request must stay high 8 ms before a sequence starts
// - qualified request does offset calibration and zeroes output value
// - separate commands for offset calibration only and zeroing only
// - null-balance sequence lasts about 0.12 s
// - serial transmission and threshold evaluation frozen during the sequence; a logger mode send still goes out while a commanded sequence runs
// - analog output flagged invalid while the sequence runs
// - logger mode: request sends one value instead of calibrating
// - offset calibration covers up to plus or minus 120 percent of range
// - two switching outputs, active pulls level low in open collector build
// - open emitter build inverts both output polarities
// - each output is threshold switch or window comparator
// - threshold switch has separate switch-on and switch-off levels
// - host writes thresholds, device uses them in comparison
// - gage factor accepted only within 0,2 to 258
`ifndef NULL_BAL_MAP_VH
`define NULL_BAL_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_CMD 8'h04
`define REG_STATUS 8'h08
`define REG_ON_A 8'h0C
`define REG_OFF_A 8'h10
`define REG_ON_B 8'h14
`define REG_OFF_B 8'h18
`define REG_GAGE 8'h1C
`define REG_OFFSET 8'h20
`define REG_ZERO 8'h24
`define REG_IRQ_STAT 8'h28
`define REG_IRQ_MASK 8'h2C
// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_FBUS 0
`define CTRL_LOGGER 1
`define CTRL_WIN_A 2
`define CTRL_WIN_B 3
`define CTRL_RESTORE 4
`define CMD_FULL 0
`define CMD_OFFSET 1
`define CMD_ZERO 2
`define ST_BUSY 0
`define ST_RELAY_A 1
`define ST_RELAY_B 2
`define ST_FBUS 3
`define EV_DONE 0
`define EV_REFUSED 1
`define EV_RELAY_A 2
`define EV_RELAY_B 3
`define EV_LOGGER 4
// ----------------------------------------
// reset values and limits
// ----------------------------------------
`define CTRL_RESET 5'h01
`define GAGE_RESET 16'h00C8
`define GAGE_MIN 16'h0014
`define GAGE_MAX 16'h64C8
`define OFFSET_PCT 120
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 100
`define QUAL_TIME_MS 8
`define SEQ_TIME_MS 120
`define TX_RATE_HZ 10
`endif

// ===== src/zreq_qualify.v
`timescale 1ns/1ps
module zreq_qualify #(
    parameter HOLD_CYCLES = 800000
)(
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // request level and qualified pulse
    input wire level_in,
    output reg qual_pulse
);
    reg [31:0] cnt_q;
    reg fired_q;

    // pulse once per high phase; short highs never reach the count
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_q <= 32'h0;
            fired_q <= 1'b0;
            qual_pulse <= 1'b0;
        end
        else
        begin
            qual_pulse <= 1'b0;
            if (!level_in)
            begin
                cnt_q <= 32'h0;
                fired_q <= 1'b0;
            end
            else if (!fired_q)
            begin
                if (cnt_q >= HOLD_CYCLES - 1)
                begin
                    fired_q <= 1'b1;
                    qual_pulse <= 1'b1;
                end
                else
                    cnt_q <= cnt_q + 32'h1;
            end
        end
    end
endmodule // zreq_qualify

// ===== src/relay_chan.v
`timescale 1ns/1ps
module relay_chan #(
    parameter W = 24
)(
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // measurement and settings
    input wire signed [W-1:0] value,
    input wire value_vld,
    input wire eval_en,
    input wire window_mode,
    input wire signed [W-1:0] on_lvl,
    input wire signed [W-1:0] off_lvl,
    input wire open_emitter,
    // result
    output reg active_q,
    output wire pin_level
);
    // open collector pulls low when active
    assign pin_level = open_emitter ? active_q : ~active_q;

    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            active_q <= 1'b0;
        else if (value_vld && eval_en)
        begin
            if (window_mode)
                active_q <= (value > off_lvl) && (value < on_lvl);
            else if (value > on_lvl)
                active_q <= 1'b1;
            else if (value < off_lvl)
                active_q <= 1'b0;
        end
    end
endmodule // relay_chan

// ===== verif/null_bal_ctrl_chk.sv
`timescale 1ns/1ps
`include "null_bal_map.vh"
module null_bal_chk #(
    parameter QUAL_CYCLES = 8,
    parameter SEQ_CYCLES = 20
)(
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pslverr,
    // request, strap and outputs
    input wire zero_req,
    input wire open_emitter,
    input wire tx_valid,
    input wire aout_valid,
    input wire relay_drive_a,
    input wire relay_drive_b
);
    reg fbus_q;
    reg [31:0] zq_cnt_q;
    reg [31:0] busy_cnt_q;
    wire wr = psel && penable && pwrite;
    wire rd_st = psel && penable && !pwrite && paddr == `REG_STATUS;
    // shadow of the lock bit: a refused set leaves it at one anyway
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            fbus_q <= 1'b1;
            zq_cnt_q <= 32'h0;
            busy_cnt_q <= 32'h0;
        end
        else
        begin
            if (wr && paddr == `REG_CTRL)
                fbus_q <= pwdata[4] | pwdata[0];
            zq_cnt_q <= zero_req ? zq_cnt_q + 32'h1 : 32'h0;
            busy_cnt_q <= aout_valid ? 32'h0 : busy_cnt_q + 32'h1;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    sequence s_locked_wr;
        wr && fbus_q && (paddr == `REG_ON_A || paddr == `REG_OFF_A || paddr == `REG_ON_B || paddr == `REG_OFF_B);
    endsequence
    sequence s_busy2;
        !aout_valid ##1 !aout_valid;
    endsequence
    property p_lock;
        s_locked_wr |-> pslverr;
    endproperty
    a_lock: assert property (p_lock) else $error("threshold write taken while locked");
    property p_fbus;
        rd_st |-> prdata[`ST_FBUS] == fbus_q;
    endproperty
    a_fbus: assert property (p_fbus) else $error("fieldbus enable state wrong");
    property p_short;
        $fell(zero_req) && zq_cnt_q < QUAL_CYCLES && aout_valid |=> aout_valid [*4];
    endproperty
    a_short: assert property (p_short) else $error("short request started a sequence");
    property p_seq_len;
        $rose(aout_valid) |-> busy_cnt_q == SEQ_CYCLES;
    endproperty
    a_seq_len: assert property (p_seq_len) else $error("sequence length wrong");
    property p_frozen;
        s_busy2 |-> $stable(relay_drive_a) && $stable(relay_drive_b) && !tx_valid;
    endproperty
    a_frozen: assert property (p_frozen) else $error("activity during sequence");
    property p_busy_stat;
        rd_st |-> prdata[`ST_BUSY] == !aout_valid;
    endproperty
    a_busy_stat: assert property (p_busy_stat) else $error("busy and analog state disagree");
    property p_pin_pol;
        rd_st |-> relay_drive_a == (prdata[`ST_RELAY_A] ~^ open_emitter)
            && relay_drive_b == (prdata[`ST_RELAY_B] ~^ open_emitter);
    endproperty
    a_pin_pol: assert property (p_pin_pol) else $error("switch pin polarity wrong");
    property p_gage;
        wr && paddr == `REG_GAGE && (pwdata < `GAGE_MIN || pwdata > `GAGE_MAX) |-> pslverr;
    endproperty
    a_gage: assert property (p_gage) else $error("gage value out of range taken");
endmodule // null_bal_chk

bind null_bal_ctrl null_bal_chk #(.QUAL_CYCLES(QUAL_CYCLES), .SEQ_CYCLES(SEQ_CYCLES)) u_chk (
    .clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .zero_req(zero_req),
    .open_emitter(open_emitter), .tx_valid(tx_valid), .aout_valid(aout_valid),
    .relay_drive_a(relay_drive_a), .relay_drive_b(relay_drive_b));

// ===== verif/meas_source.sv
`timescale 1ns/1ps
module meas_source #(
    parameter W = 24,
    parameter GAP = 4
)(
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // level to report
    input wire signed [W-1:0] level,
    // sample stream
    output reg signed [W-1:0] meas_raw,
    output reg meas_vld
);
    integer cnt_q;
    // between strobes the data is inverted, so stale sampling shows up
    always @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            cnt_q <= 0;
            meas_vld <= 1'b0;
            meas_raw <= {W{1'b0}};
        end
        else
        begin
            cnt_q <= (cnt_q == GAP - 1) ? 0 : cnt_q + 1;
            meas_vld <= (cnt_q == GAP - 1);
            meas_raw <= (cnt_q == GAP - 1) ? level : ~level;
        end
    end
endmodule // meas_source

// ===== verif/null_bal_ctrl_tb.sv
`timescale 1ns/1ps
`include "null_bal_map.vh"
module null_bal_ctrl_tb;
    localparam QUAL = 8;
    localparam SEQ = 20;
    localparam [31:0] CLAMP = 32'h3FFFFF * 120 / 100;
    reg clk_sys, nrst, psel, penable, pwrite, zero_req, open_emitter, er;
    reg [7:0] paddr;
    reg [31:0] pwdata, rd;
    reg [23:0] level;
    wire [31:0] prdata;
    wire pready, pslverr, meas_vld, tx_valid, aout_valid, relay_drive_a, relay_drive_b, irq;
    wire [23:0] meas_raw, tx_data;
    integer n_errors, checks_done, cyc, n_tx, n_tx_busy, n_low, i, j;
    meas_source u_src (.clk_sys(clk_sys), .nrst(nrst), .level(level), .meas_raw(meas_raw), .meas_vld(meas_vld));
    null_bal_ctrl #(.QUAL_CYCLES(QUAL), .SEQ_CYCLES(SEQ), .TX_CYCLES(16)) u_dut (.clk_sys(clk_sys),
        .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas_raw(meas_raw), .meas_vld(meas_vld),
        .zero_req(zero_req), .open_emitter(open_emitter), .tx_data(tx_data), .tx_valid(tx_valid),
        .aout_valid(aout_valid), .relay_drive_a(relay_drive_a), .relay_drive_b(relay_drive_b), .irq(irq));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task end_sim;
    begin
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    task chk(input string nm, input [31:0] got, input [31:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    end
    endtask
    task chk1(input string nm, input got, input exp);
        chk(nm, {31'h0, got}, {31'h0, exp});
    endtask
    task apb(input w, input [7:0] a, input [31:0] d);
    begin
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clk_sys);
    end
    endtask
    task wr(input [7:0] a, input [31:0] d, input e);
    begin
        apb(1'b1, a, d);
        chk1($sformatf("error on write %h", a), er, e);
    end
    endtask
    task rdc(input [7:0] a, input [31:0] e);
    begin
        apb(1'b0, a, 32'h0);
        chk($sformatf("read %h", a), rd, e);
    end
    endtask
    task settle;
        repeat (12) @(posedge clk_sys);
    endtask
    task set_lv(input [23:0] v);
    begin
        level <= v;
        settle;
    end
    endtask
    task zpulse(input integer n);
    begin
        @(posedge clk_sys);
        zero_req <= 1'b1;
        repeat (n) @(posedge clk_sys);
        zero_req <= 1'b0;
    end
    endtask
    task wait_av(input v);
    begin
        i = 0;
        while (aout_valid !== v && i < 200)
        begin
            i = i + 1;
            @(posedge clk_sys);
        end
        chk1("aout_valid", aout_valid, v);
    end
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys)
    begin
        cyc = cyc + 1;
        n_tx = n_tx + (tx_valid === 1'b1);
        n_tx_busy = n_tx_busy + (tx_valid === 1'b1 && aout_valid === 1'b0);
        n_low = n_low + (aout_valid === 1'b0);
        if (cyc == 20000)
        begin
            n_errors = n_errors + 1;
            end_sim;
        end
    end
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial
    begin
        {nrst, psel, penable, pwrite, zero_req, open_emitter, paddr, pwdata, level} = 0;
        {n_errors, checks_done, cyc, n_tx, n_tx_busy, n_low} = 0;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        rdc(`REG_CTRL, 32'h1);
        rdc(`REG_GAGE, {16'h0, `GAGE_RESET});
        wr(`REG_ON_A, 32'd100, 1'b1);
        rdc(`REG_IRQ_STAT, 32'h2);
        wr(`REG_CTRL, 32'h8, 1'b0);
        wr(`REG_ON_A, 32'd100, 1'b0);
        wr(`REG_OFF_A, 32'd50, 1'b0);
        wr(`REG_ON_B, 32'd100, 1'b0);
        wr(`REG_OFF_B, 32'd50, 1'b0);
        rdc(`REG_OFF_A, 32'd50);
        wr(`REG_GAGE, {16'h0, `GAGE_MIN - 16'h1}, 1'b1);
        wr(`REG_GAGE, {16'h0, `GAGE_MIN}, 1'b0);
        wr(`REG_GAGE, {16'h0, `GAGE_MAX + 16'h1}, 1'b1);
        wr(`REG_GAGE, {16'h0, `GAGE_MAX}, 1'b0);
        set_lv(24'd120);
        chk1("relay a", relay_drive_a, 1'b0);
        chk1("relay b", relay_drive_b, 1'b1);
        set_lv(24'd80);
        chk1("relay a", relay_drive_a, 1'b0);
        chk1("relay b", relay_drive_b, 1'b0);
        set_lv(24'd120);
        open_emitter <= 1'b1;
        @(posedge clk_sys);
        chk1("relay a", relay_drive_a, 1'b1);
        chk1("relay b", relay_drive_b, 1'b0);
        rdc(`REG_STATUS, 32'h2);
        open_emitter <= 1'b0;
        set_lv(24'd40);
        chk1("relay a", relay_drive_a, 1'b1);
        wr(`REG_IRQ_STAT, 32'h1F, 1'b0);
        wr(`REG_IRQ_MASK, 32'h0, 1'b0);
        zpulse(QUAL - 3);
        settle;
        chk("busy cycles", n_low, 0);
        zpulse(QUAL + 4);
        wait_av(1'b0);
        rdc(`REG_STATUS, 32'h1);
        set_lv(24'd300);
        chk1("relay a", relay_drive_a, 1'b1);
        wait_av(1'b1);
        chk("tx in busy", n_tx_busy, 0);
        rdc(`REG_OFFSET, 32'd300);
        j = n_tx;
        settle;
        chk1("relay a", relay_drive_a, 1'b1);
        rdc(`REG_IRQ_STAT, 32'h1);
        chk1("irq", irq, 1'b0);
        wr(`REG_IRQ_MASK, 32'h1, 1'b0);
        chk1("irq", irq, 1'b1);
        wr(`REG_IRQ_STAT, 32'h1, 1'b0);
        chk1("irq", irq, 1'b0);
        chk1("tx resumed", n_tx > j, 1'b1);
        set_lv(24'd350);
        wr(`REG_CMD, 32'h4, 1'b0);
        wait_av(1'b0);
        wait_av(1'b1);
        rdc(`REG_OFFSET, 32'd300);
        set_lv(24'd500);
        wr(`REG_CMD, 32'h2, 1'b0);
        wait_av(1'b0);
        wait_av(1'b1);
        rdc(`REG_OFFSET, 32'd500);
        set_lv(24'h7FFFFF);
        wr(`REG_CMD, 32'h2, 1'b0);
        wait_av(1'b0);
        wait_av(1'b1);
        rdc(`REG_OFFSET, CLAMP);
        wr(`REG_CTRL, 32'h2, 1'b0);
        settle;
        j = n_tx;
        i = n_low;
        zpulse(QUAL + 4);
        settle;
        chk("logger sends", n_tx - j, 1);
        chk("logger busy", n_low - i, 0);
        wr(`REG_CTRL, 32'h10, 1'b0);
        rdc(`REG_CTRL, 32'h1);
        wr(`REG_OFF_B, 32'd10, 1'b1);
        apb(1'b0, 8'h30, 32'h0);
        chk1("unmapped error", er, 1'b1);
        chk("unmapped data", rd, 32'h0);
        end_sim;
    end
endmodule // null_bal_ctrl_tb
